// ==== hw/hsc_channel_ctrl.sv ====
/*
 * two-channel hot-swap enable and protection policy with its registers.
 * assumes analog comparators and straps arrive as asynchronous levels,
 * and that the host reaches the registers over the serial target.
 */
// Functional notes
// RL1 - enable vote: at least two of host, hardware, on bits
// RL2 - switch on only with supply above lockout and vote true
// RL3 - supply rise loads hardware bits from enable pin
// RL4 - host bits 0 after reset until written
// RL5 - on states read back: bit 0 ch1, bit 1 ch2
// RL6 - host writes host and hardware bits of either channel
// RL7 - grouping low: fault stops only its own channel
// RL8 - grouping high or open: a fault stops both, converter shared
// RL9 - grouping status bit reads 0 when paired
// RL10 - critical code: 00 alert, 01 drop power good, 10 shut down
// RL11 - status register: response bits 7:6, grouping bit 4, on states 1:0
// RL12 - enable register: ch1 host/hw bits 0/1, ch2 bits 2/3, rest unused
// RL13 - gate on below both trips, off when either trips
// RL14 - fast trip: 8-bit code in 25, 50 or 100 mV range
// RL15 - slow trip derived from fast via ratio, lower unless fast is 0
// RL16 - ratio register: ch1 bits 1:0, ch2 bits 3:2, reset 0x0f
// RL17 - ratio codes 00..11 mean 125, 150, 175, 200 percent
// RL18 - vote re-evaluated continuously; off once it fails
module hsc_channel_ctrl #(
    parameter int CHANNELS = 2,
    parameter logic [6:0] DEV_ADDR = hsc_pkg::TARGET_ADDR
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clkEnable,
    // serial host pins
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // supply and strap pins
    input wire logic supplyAboveLockout,
    input wire logic hardwareEnablePin,
    input wire logic groupingPin,
    input wire logic [1:0] faultResponsePins,
    input wire logic [3:0] senseRangePin,
    // per-channel comparator pins
    input wire logic [1:0] onState,
    input wire logic [1:0] slowTripHit,
    input wire logic [1:0] fastTripHit,
    input wire logic [1:0] criticalUvOv,
    // channel outputs
    output logic [1:0] gateOn,
    output logic [1:0] powerGood,
    output logic [1:0] faultShutdown,
    output logic alert,
    output logic monitorShared,
    // threshold codes, lsb = 25 mV / 255
    output logic [1:0][9:0] fastTripLevel,
    output logic [1:0][9:0] slowTripLevel
);
    import hsc_pkg::*;

    localparam int PIN_W = 17;

    // slow-trip factor for a ratio select code
    function automatic logic [7:0] slowFactor(input logic [1:0] sel);
        unique case (sel)
            2'h0: slowFactor = SLOW_K_125;
            2'h1: slowFactor = SLOW_K_150;
            2'h2: slowFactor = SLOW_K_175;
            default: slowFactor = SLOW_K_200;
        endcase
    endfunction : slowFactor

    // full-scale code to left shift of the threshold code
    function automatic logic [1:0] rangeShift(input logic [1:0] code);
        unique case (code)
            RANGE_25MV: rangeShift = 2'h0;
            RANGE_50MV: rangeShift = 2'h1;
            default: rangeShift = 2'h2;
        endcase
    endfunction : rangeShift

    logic [PIN_W-1:0] pinMeta_q;
    logic [PIN_W-1:0] pinSync_q;
    logic supplyPrev_q;
    logic [3:0] enable_q;
    logic [3:0] ratio_q;
    logic [3:0] range_q;
    logic [1:0][7:0] dac_q;
    logic [1:0] fault_q;
    logic [1:0] gate_q;
    logic [1:0] pgood_q;
    logic alert_q;
    logic [1:0][9:0] fast_q;
    logic [1:0][9:0] slow_q;
    logic [7:0] regAddr;
    logic [7:0] rdData;
    logic wrStb;
    logic [7:0] wrAddr;
    logic [7:0] wrData;

    // serial target for host register access
    hsc_i2c_target #(
        .DEV_ADDR(DEV_ADDR)
    ) u_target (.*);

    // two-flop synchroniser for every asynchronous pin
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pinMeta_q <= '0;
            pinSync_q <= '0;
        end else if (clkEnable) begin
            pinMeta_q <= {supplyAboveLockout, hardwareEnablePin, groupingPin,
                          faultResponsePins, senseRangePin, onState,
                          slowTripHit, fastTripHit, criticalUvOv};
            pinSync_q <= pinMeta_q;
        end
    end

    // synchronised pin fields
    wire supplyOk = pinSync_q[16];
    wire hwEnLevel = pinSync_q[15];
    wire paired = pinSync_q[14];
    wire [1:0] protCode = pinSync_q[13:12];
    wire [3:0] rangePins = pinSync_q[11:8];
    wire [1:0] onSync = pinSync_q[7:6];
    wire [1:0] slowSync = pinSync_q[5:4];
    wire [1:0] fastSync = pinSync_q[3:2];
    wire [1:0] critSync = pinSync_q[1:0];
    wire supplyRise = supplyOk & ~supplyPrev_q;

    // register write decode
    wire wrEnable = wrStb & (wrAddr == REG_ENABLE);
    wire wrRatio = wrStb & (wrAddr == REG_RATIO);
    wire wrRange = wrStb & (wrAddr == REG_RANGE);
    wire [1:0] wrDac = {wrStb & (wrAddr == REG_DAC_CH2), wrStb & (wrAddr == REG_DAC_CH1)};

    // fault policy decode from the response code
    wire critDropsPg = (protCode != PROT_ALERT); // see RL10
    wire critShuts = protCode[1]; // see RL10

    // status read value
    wire [7:0] statusValue = {protCode, 1'b0, ~paired, 2'b00, onSync}; // see RL5, RL9, RL11

    // read mux; unmapped offsets read zero
    assign rdData = (regAddr == REG_STATUS) ? statusValue :
                    (regAddr == REG_ENABLE) ? {4'h0, enable_q} :
                    (regAddr == REG_RATIO) ? {4'h0, ratio_q} :
                    (regAddr == REG_RANGE) ? {4'h0, range_q} :
                    (regAddr == REG_DAC_CH1) ? dac_q[0] :
                    (regAddr == REG_DAC_CH2) ? dac_q[1] : 8'h00;

    // supply edge tracking for the hardware enable seed
    always_ff @(posedge core_clk) begin
        if (reset) begin
            supplyPrev_q <= 1'b0;
        end else if (clkEnable) begin
            supplyPrev_q <= supplyOk;
        end
    end

    // enable bits: host writes, hardware bits reseeded on supply rise
    always_ff @(posedge core_clk) begin
        if (reset) begin
            enable_q <= ENABLE_RST; // see RL4
        end else if (clkEnable) begin
            if (wrEnable) begin
                enable_q <= wrData[3:0]; // see RL6, RL12
            end
            if (supplyRise) begin
                enable_q[EN_HW_POS] <= hwEnLevel; // see RL3
                enable_q[EN_HW_POS + EN_STRIDE] <= hwEnLevel; // see RL3
            end
        end
    end

    // ratio, sense range and threshold code registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ratio_q <= RATIO_RST; // see RL16, RL17
            range_q <= RANGE_RST;
            dac_q <= {DAC_RST, DAC_RST};
        end else if (clkEnable) begin
            if (wrRatio) begin
                ratio_q <= wrData[3:0]; // see RL16
            end
            if (supplyRise) begin
                range_q <= rangePins;
            end else if (wrRange) begin
                range_q <= wrData[3:0];
            end
            if (wrDac[0]) begin
                dac_q[0] <= wrData;
            end
            if (wrDac[1]) begin
                dac_q[1] <= wrData;
            end
        end
    end

    // per-channel decisions
    logic [1:0] vote;
    logic [1:0] tripNow;
    logic [1:0] ownShut;
    logic [1:0] faultSet;
    logic [1:0] faultClr;
    logic [1:0] faultNext;
    logic [1:0][9:0] fastCalc;
    logic [1:0][17:0] slowProd;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
            wire hostBit = enable_q[EN_HOST_POS + EN_STRIDE * ch];
            wire hwBit = enable_q[EN_HW_POS + EN_STRIDE * ch];
            // two-of-three majority vote
            assign vote[ch] = (hostBit & hwBit) | (hostBit & onSync[ch]) | (hwBit & onSync[ch]); // see RL1
            // either comparator over its threshold
            assign tripNow[ch] = slowSync[ch] | fastSync[ch]; // see RL13
            assign ownShut[ch] = tripNow[ch] | (critSync[ch] & critShuts); // see RL10
            // a grouped pair shares every shutdown
            assign faultSet[ch] = paired ? (|ownShut) : ownShut[ch]; // see RL7, RL8
            // dropping the vote or supply rearms the channel
            assign faultClr[ch] = ~vote[ch] | ~supplyOk; // see RL18
            // a new shutdown wins over a clear in the same cycle
            assign faultNext[ch] = faultSet[ch] | (fault_q[ch] & ~faultClr[ch]);
            // threshold scaling into the selected full-scale range
            assign fastCalc[ch] = {2'b00, dac_q[ch]} << rangeShift(range_q[2*ch +: 2]); // see RL14
            assign slowProd[ch] = fastCalc[ch] * slowFactor(ratio_q[2*ch +: 2]); // see RL15, RL17
        end
    endgenerate

    // fault latches and gate drive
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fault_q <= 2'b00;
            gate_q <= 2'b00;
            pgood_q <= 2'b00;
            alert_q <= 1'b0;
        end else if (clkEnable) begin
            fault_q <= faultNext;
            gate_q <= {2{supplyOk}} & vote & ~faultNext; // see RL2, RL13, RL18
            pgood_q <= {2{supplyOk}} & vote & ~faultNext & ~(critSync & {2{critDropsPg}}); // see RL10
            alert_q <= |critSync; // see RL10
        end
    end

    // registered threshold codes; the factor is below 256 so slow stays under any nonzero fast
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fast_q <= '0;
            slow_q <= '0;
        end else if (clkEnable) begin
            fast_q <= fastCalc; // see RL14
            slow_q <= {slowProd[1][17:8], slowProd[0][17:8]}; // see RL15
        end
    end

    // output drive
    assign gateOn = gate_q;
    assign powerGood = pgood_q;
    assign faultShutdown = fault_q;
    assign alert = alert_q;
    assign monitorShared = paired; // see RL8
    assign fastTripLevel = fast_q;
    assign slowTripLevel = slow_q;
endmodule : hsc_channel_ctrl

// ==== hw/hsc_i2c_target.sv ====
/*
 * byte-wide two-wire serial target: device address, register pointer,
 * auto-incrementing writes and reads.
 * assumes scl and sda come from pins; both pass two flip-flops here.
 */
module hsc_i2c_target #(
    parameter logic [6:0] DEV_ADDR = hsc_pkg::TARGET_ADDR
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clkEnable,
    // serial pins
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // register side
    output logic [7:0] regAddr,
    input wire logic [7:0] rdData,
    output logic wrStb,
    output logic [7:0] wrAddr,
    output logic [7:0] wrData
);
    import hsc_pkg::*;

    hsc_state_t st_q;
    logic [1:0] sclSync_q;
    logic [1:0] sdaSync_q;
    logic sclPrev_q;
    logic sdaPrev_q;
    logic [2:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] ptr_q;
    logic rdMode_q;
    logic seen_q;
    logic oe_q;
    logic wrStb_q;
    logic [7:0] wrAddr_q;
    logic [7:0] wrData_q;

    // bus condition decode on the synchronised lines
    wire sclS = sclSync_q[1];
    wire sdaS = sdaSync_q[1];
    wire sclRise = sclS & ~sclPrev_q;
    wire sclFall = ~sclS & sclPrev_q;
    wire startCond = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
    wire stopCond = sclS & sclPrev_q & ~sdaPrev_q & sdaS;
    wire lastBit = (cnt_q == 3'h7);

    // two-flop synchronisers, then one edge-detect stage
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sclSync_q <= 2'h3;
            sdaSync_q <= 2'h3;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else if (clkEnable) begin
            sclSync_q <= {sclSync_q[0], scl};
            sdaSync_q <= {sdaSync_q[0], sdaIn};
            sclPrev_q <= sclS;
            sdaPrev_q <= sdaS;
        end
    end

    // protocol sequencer; data changes only after scl falls
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q <= HSC_IDLE;
            cnt_q <= 3'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            rdMode_q <= 1'b0;
            seen_q <= 1'b0;
            oe_q <= 1'b0;
            wrStb_q <= 1'b0;
            wrAddr_q <= 8'h00;
            wrData_q <= 8'h00;
        end else if (clkEnable) begin
            wrStb_q <= 1'b0;
            if (startCond) begin
                st_q <= HSC_ADDR;
                cnt_q <= 3'h0;
                seen_q <= 1'b0; // the scl fall closing the start is no data bit
                oe_q <= 1'b0;
            end else if (stopCond) begin
                st_q <= HSC_IDLE;
                oe_q <= 1'b0;
            end else begin
                unique case (st_q)
                    HSC_IDLE: begin
                        oe_q <= 1'b0;
                    end
                    HSC_ADDR, HSC_PTR, HSC_WR: begin
                        if (sclRise) begin
                            sh_q <= {sh_q[6:0], sdaS};
                            seen_q <= 1'b1;
                        end
                        if (sclFall && seen_q) begin
                            cnt_q <= cnt_q + 3'h1;
                            if (lastBit && st_q == HSC_ADDR) begin
                                rdMode_q <= sh_q[0];
                                oe_q <= (sh_q[7:1] == DEV_ADDR);
                                st_q <= (sh_q[7:1] == DEV_ADDR) ? HSC_ACKA : HSC_IDLE;
                            end else if (lastBit && st_q == HSC_PTR) begin
                                ptr_q <= sh_q;
                                oe_q <= 1'b1;
                                st_q <= HSC_ACKP;
                            end else if (lastBit) begin
                                wrStb_q <= 1'b1;
                                wrAddr_q <= ptr_q;
                                wrData_q <= sh_q;
                                ptr_q <= ptr_q + 8'h01;
                                oe_q <= 1'b1;
                                st_q <= HSC_ACKW;
                            end
                        end
                    end
                    HSC_ACKA, HSC_ACKR: begin
                        if (sclRise && st_q == HSC_ACKR && sdaS) begin
                            st_q <= HSC_IDLE;
                        end else if (sclFall && (rdMode_q || st_q == HSC_ACKR)) begin
                            sh_q <= rdData;
                            oe_q <= ~rdData[7];
                            ptr_q <= ptr_q + 8'h01;
                            cnt_q <= 3'h0;
                            st_q <= HSC_RD;
                        end else if (sclFall) begin
                            oe_q <= 1'b0;
                            cnt_q <= 3'h0;
                            st_q <= HSC_PTR;
                        end
                    end
                    HSC_ACKP, HSC_ACKW: begin
                        if (sclFall) begin
                            oe_q <= 1'b0;
                            cnt_q <= 3'h0;
                            st_q <= HSC_WR;
                        end
                    end
                    HSC_RD: begin
                        if (sclFall) begin
                            cnt_q <= cnt_q + 3'h1;
                            sh_q <= {sh_q[6:0], 1'b0};
                            oe_q <= lastBit ? 1'b0 : ~sh_q[6];
                            if (lastBit) begin
                                st_q <= HSC_ACKR;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // open-drain drive: the line is only ever pulled low
    assign sdaOut = 1'b0;
    assign sdaOe = oe_q;
    assign regAddr = ptr_q;
    assign wrStb = wrStb_q;
    assign wrAddr = wrAddr_q;
    assign wrData = wrData_q;
endmodule : hsc_i2c_target

// ==== hw/hsc_pkg.sv ====
/*
 * shared constants for the hot-swap channel enable control block:
 * register offsets, field positions, reset values and policy codes.
 * assumes a single 50 MHz core clock and an 8-bit register space.
 */
package hsc_pkg;
    // register offsets
    localparam logic [7:0] REG_DAC_CH1 = 8'h2e;
    localparam logic [7:0] REG_DAC_CH2 = 8'h2f;
    localparam logic [7:0] REG_RATIO = 8'h30;
    localparam logic [7:0] REG_STATUS = 8'h32;
    localparam logic [7:0] REG_RANGE = 8'h33;
    localparam logic [7:0] REG_ENABLE = 8'h3b;
    // reset values
    localparam logic [3:0] RATIO_RST = 4'hf;
    localparam logic [7:0] DAC_RST = 8'hbf;
    localparam logic [3:0] ENABLE_RST = 4'h0;
    localparam logic [3:0] RANGE_RST = 4'ha;
    // field positions
    localparam int STAT_PROT_POS = 6;
    localparam int STAT_GROUP_POS = 4;
    localparam int STAT_ON_POS = 0;
    localparam int EN_HOST_POS = 0;
    localparam int EN_HW_POS = 1;
    localparam int EN_STRIDE = 2;
    // fault-response codes
    localparam logic [1:0] PROT_ALERT = 2'h0;
    localparam logic [1:0] PROT_PGOOD = 2'h1;
    localparam logic [1:0] PROT_SHUT = 2'h2;
    // full-scale sense range codes: 25, 50, 100 mV
    localparam logic [1:0] RANGE_25MV = 2'h0;
    localparam logic [1:0] RANGE_50MV = 2'h1;
    localparam logic [1:0] RANGE_100MV = 2'h2;
    // slow = fast * factor / 256 for ratios 125, 150, 175, 200 percent
    localparam logic [7:0] SLOW_K_125 = 8'hcd;
    localparam logic [7:0] SLOW_K_150 = 8'hab;
    localparam logic [7:0] SLOW_K_175 = 8'h92;
    localparam logic [7:0] SLOW_K_200 = 8'h80;
    // serial target address, arbitrary value
    localparam logic [6:0] TARGET_ADDR = 7'h3a;
    // serial target states
    typedef enum logic [8:0] {
        HSC_IDLE = 9'h001,
        HSC_ADDR = 9'h002,
        HSC_ACKA = 9'h004,
        HSC_PTR = 9'h008,
        HSC_ACKP = 9'h010,
        HSC_WR = 9'h020,
        HSC_ACKW = 9'h040,
        HSC_RD = 9'h080,
        HSC_ACKR = 9'h100
    } hsc_state_t;
endpackage : hsc_pkg

// ==== tb/hsc_chk.sv ====
/* timing checks on the channel control block ports.
   assumes one clock domain and pins that pass a two-flop synchroniser. */
module hsc_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // supply, strap and comparator pins
    input wire logic supplyAboveLockout,
    input wire logic groupingPin,
    input wire logic [1:0] faultResponsePins,
    input wire logic [1:0] slowTripHit,
    input wire logic [1:0] fastTripHit,
    input wire logic [1:0] criticalUvOv,
    // channel outputs
    input wire logic [1:0] gateOn,
    input wire logic [1:0] powerGood,
    input wire logic [1:0] faultShutdown,
    input wire logic alert,
    input wire logic monitorShared,
    input wire logic [1:0][9:0] fastTripLevel,
    input wire logic [1:0][9:0] slowTripLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    import hsc_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    logic cause1;
    logic [4:0] causeHist_q;
    // causes of a channel 2 fault
    assign cause1 = slowTripHit[1] | fastTripHit[1] | (criticalUvOv[1] & faultResponsePins[1])
        | (groupingPin & (slowTripHit[0] | fastTripHit[0] | (criticalUvOv[0] & faultResponsePins[1])));
    // recent causes
    always_ff @(posedge core_clk) begin
        if (reset) begin
            causeHist_q <= 5'h00;
        end else begin
            causeHist_q <= {causeHist_q[3:0], cause1};
        end
    end
    // gate, fault, power-good and alert policy
    chk_gate_supply: assert property (
        (!supplyAboveLockout)[*5] |-> gateOn == 2'h0) else $error("gate on with supply low");
    chk_trip_gate: assert property (
        (fastTripHit[0])[*5] |-> !gateOn[0]) else $error("gate on during fast trip");
    chk_pair_both: assert property (
        (groupingPin && slowTripHit[1])[*5] |-> gateOn == 2'h0) else $error("pair not shut down");
    chk_fault_cause: assert property (
        $rose(faultShutdown[1]) |-> |causeHist_q) else $error("fault latched without cause");
    chk_pgood_drop: assert property (
        (criticalUvOv[0] && faultResponsePins != PROT_ALERT)[*5] |-> !powerGood[0])
        else $error("power good kept on critical event");
    chk_alert_raise: assert property (
        (criticalUvOv[0])[*5] |-> alert) else $error("alert missing on critical event");
    // thresholds and grouping report
    chk_slow_below: assert property (
        fastTripLevel[0] != 10'h000 && $stable(fastTripLevel[0]) |-> ##1 slowTripLevel[0] < fastTripLevel[0])
        else $error("slow trip not below fast trip");
    chk_group_shared: assert property (
        (groupingPin)[*4] |-> monitorShared) else $error("monitor not shared when paired");
    // main scenarios reached
    cover property ($rose(gateOn[0]));
    cover property ($rose(faultShutdown[1]));
    cover property (faultShutdown == 2'h3);
endmodule : hsc_chk

bind hsc_channel_ctrl hsc_chk hsc_chk_i (.*);

// ==== tb/hsc_host_model.sv ====
/* serial host model: start, stop, byte out and in, 8-clock half bits.
   assumes an open-drain data line with a pull-up resolved by the bench. */
module hsc_host_model (
    // clock
    input wire logic core_clk,
    // serial pins
    output logic scl,
    output logic sdaPull,
    input wire logic sdaLine
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus: clock high, line released
    initial begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end
    // half a bit period
    task automatic half();
        repeat (8) @(posedge core_clk);
    endtask : half
    // start or repeated start, leaves the clock low
    task automatic start();
        sdaPull <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sdaPull <= 1'b1;
        half();
        scl <= 1'b0;
        half();
    endtask : start
    // stop, leaves the bus idle
    task automatic stop();
        sdaPull <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sdaPull <= 1'b0;
        half();
    endtask : stop
    // data moves two clocks after the clock falls, sampled at end of high
    task automatic bitIo(input logic b, output logic r);
        sdaPull <= ~b;
        half();
        scl <= 1'b1;
        half();
        r = sdaLine;
        scl <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : bitIo
    // byte out msb first, returns the target acknowledge
    task automatic byteOut(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitIo(b[i], r);
        end
        bitIo(1'b1, r);
        ack = ~r;
    endtask : byteOut
    // byte in msb first, then acknowledge or, on the last, release
    task automatic byteIn(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitIo(1'b1, r);
            b[i] = r;
        end
        bitIo(last, r);
    endtask : byteIn
endmodule : hsc_host_model

// ==== tb/testbench.sv ====
/* self-checking bench for the hot-swap channel control block.
   assumes the host model for register access and a pulled-up data line. */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import hsc_pkg::*;
    logic core_clk = 1'b0, reset = 1'b1, clkEnable = 1'b1, supplyAboveLockout = 1'b0;
    logic hardwareEnablePin = 1'b1, groupingPin = 1'b0;
    logic [1:0] faultResponsePins = 2'h2;
    logic [3:0] senseRangePin = 4'ha;
    logic [1:0] onState = 2'h0, slowTripHit = 2'h0, fastTripHit = 2'h0, criticalUvOv = 2'h0;
    logic scl, sdaPull, sdaOut, sdaOe, alert, monitorShared, ack;
    logic [1:0] gateOn, powerGood, faultShutdown;
    logic [1:0][9:0] fastTripLevel, slowTripLevel;
    logic [7:0] rd;
    int error_cnt = 0;
    int num_checks = 0;
    // open-drain line with pull-up
    wire sdaLine = ~(sdaOe | sdaPull);
    // 50 MHz clock
    always #10 core_clk = ~core_clk;
    // block under test and its host
    hsc_channel_ctrl hsc_channel_ctrl_i (.sdaIn(sdaLine), .*);
    hsc_host_model hsc_host_model_i (.*);
    // comparison, verdict and serial access
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task automatic settle();
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
    endtask : settle
    task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        hsc_host_model_i.start();
        hsc_host_model_i.byteOut({TARGET_ADDR, 1'b0}, ack);
        hsc_host_model_i.byteOut(a, ack);
        hsc_host_model_i.byteOut(d, ack);
        hsc_host_model_i.stop();
    endtask : wrReg
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        hsc_host_model_i.start();
        hsc_host_model_i.byteOut({TARGET_ADDR, 1'b0}, ack);
        hsc_host_model_i.byteOut(a, ack);
        hsc_host_model_i.start();
        hsc_host_model_i.byteOut({TARGET_ADDR, 1'b1}, ack);
        hsc_host_model_i.byteIn(1'b1, rd);
        hsc_host_model_i.stop();
        chk(16'(rd), 16'(exp));
    endtask : rdChk
    // dropping the vote, like dropping the supply, clears a latched fault
    task automatic clearFault();
        wrReg(REG_ENABLE, 8'h00);
        wrReg(REG_ENABLE, 8'h05);
        settle();
    endtask : clearFault
    // slow factor out of 256 for ratio code k, rounded
    function automatic int kOf(input int k);
        return (25600 + (125 + 25 * k) / 2) / (125 + 25 * k);
    endfunction : kOf
    // watchdog
    initial begin
        repeat (60000) @(posedge core_clk);
        error_cnt++;
        print_verdict();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        rdChk(REG_ENABLE, 8'h00);
        rdChk(REG_RATIO, 8'h0f);
        chk(16'(slowTripLevel[0]), 16'h17e);
        @(posedge core_clk) supplyAboveLockout <= 1'b1;
        settle();
        rdChk(REG_ENABLE, 8'h0a);
        @(posedge core_clk) onState <= 2'h1;
        wrReg(REG_STATUS, 8'h00);
        settle();
        rdChk(REG_STATUS, 8'h91);
        @(posedge core_clk) groupingPin <= 1'b1;
        @(posedge core_clk) onState <= 2'h2;
        settle();
        rdChk(REG_STATUS, 8'h82);
        @(posedge core_clk) groupingPin <= 1'b0;
        for (int v = 0; v < 8; v++) begin
            wrReg(REG_ENABLE, 8'(v % 4 * 5));
            @(posedge core_clk) onState <= {2{v[2]}};
            settle();
            chk(16'(gateOn), 16'(v == 3 || v >= 5 ? 3 : 0));
        end
        wrReg(REG_ENABLE, 8'hff);
        rdChk(REG_ENABLE, 8'h0f);
        @(posedge core_clk) supplyAboveLockout <= 1'b0;
        settle();
        chk(16'(gateOn), 16'h0);
        @(posedge core_clk) hardwareEnablePin <= 1'b0;
        @(posedge core_clk) supplyAboveLockout <= 1'b1;
        settle();
        rdChk(REG_ENABLE, 8'h05);
        chk(16'(gateOn), 16'h3);
        @(posedge core_clk) fastTripHit <= 2'h1;
        settle();
        @(posedge core_clk) fastTripHit <= 2'h0;
        settle();
        chk(16'(gateOn), 16'h2);
        chk(16'(faultShutdown), 16'h1);
        clearFault();
        @(posedge core_clk) groupingPin <= 1'b1;
        @(posedge core_clk) slowTripHit <= 2'h2;
        settle();
        @(posedge core_clk) slowTripHit <= 2'h0;
        settle();
        chk(16'(gateOn), 16'h0);
        chk(16'(faultShutdown), 16'h3);
        clearFault();
        @(posedge core_clk) groupingPin <= 1'b0;
        for (int c = 0; c < 3; c++) begin
            @(posedge core_clk) faultResponsePins <= 2'(c);
            @(posedge core_clk) criticalUvOv <= 2'h1;
            settle();
            chk(16'(alert), 16'h1);
            chk(16'(powerGood), 16'(c == 0 ? 3 : 2));
            chk(16'(gateOn), 16'(c == 2 ? 2 : 3));
            @(posedge core_clk) criticalUvOv <= 2'h0;
            clearFault();
        end
        for (int k = 0; k < 4; k++) begin
            wrReg(REG_RATIO, 8'(12 + k));
            settle();
            chk(16'(slowTripLevel[0]), 16'((764 * kOf(k)) >> 8));
            chk(16'(slowTripLevel[1]), 16'h17e);
        end
        wrReg(REG_DAC_CH1, 8'h40);
        for (int r = 0; r < 3; r++) begin
            wrReg(REG_RANGE, 8'(8 + r));
            settle();
            chk(16'(fastTripLevel[0]), 16'(64 << r));
            chk(16'(fastTripLevel[1]), 16'h2fc);
        end
        rdChk(8'h50, 8'h00);
        @(posedge core_clk);
        hsc_host_model_i.start();
        hsc_host_model_i.byteOut(8'h10, ack);
        hsc_host_model_i.stop();
        chk(16'(ack), 16'h0);
        print_verdict();
    end
endmodule : testbench
